// ==== hdl/sleep_sync_coordinator.sv ====
// Implementation choices: the register addresses and the APB register port.
module sleep_sync_coordinator import sleep_sync_pkg::*; #(
    parameter int unsigned MS_TICK_CYC = MS_TICK_DEFAULT
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_commission_btn,
    input wire logic i_sync_rx_valid,
    input wire sync_msg_t i_sync_rx_msg,
    input wire logic i_sync_req_rx,
    output logic o_sync_tx_valid,
    output sync_msg_t o_sync_tx_msg,
    output logic o_sync_req_tx,
    output logic o_awake,
    output logic o_assoc_led,
    output logic o_coordinator,
    output logic [TW-1:0] o_guard_ms,
    output logic [TW-1:0] o_tx_window_ms
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // clip a wide time to the field width
    function automatic logic [TW-1:0] clip(input logic [23:0] v);
        clip = (v > 24'(16'hFFFF)) ? 16'hFFFF : v[TW-1:0];
    endfunction : clip

    // subtract, never below one ms
    function automatic logic [TW-1:0] sub_min1(input logic [TW-1:0] a, input logic [23:0] b);
        sub_min1 = (b >= 24'(a)) ? 16'h0001 : a - b[TW-1:0];
    endfunction : sub_min1

    // propagation estimate from the net register
    function automatic logic [23:0] calc_sync_propagation_time(input logic [31:0] net);
        calc_sync_propagation_time = 24'(net[NET_SLOT_LSB +: 8] * net[NET_HOP_LSB +: 8]) * 24'(SYNC_PROPAGATION_TIME_UNIT_MS);
    endfunction : calc_sync_propagation_time

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [31:0] tick_cnt_reg;                   // ms prescaler
    logic pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;
    logic [CW-1:0] ctrl_reg;                     // mode and options
    logic [TW-1:0] sleep_reg, wake_reg;          // local settings
    logic [31:0] net_reg;                        // hop and slot counts
    sync_msg_t net_msg_reg;                      // values in use by network
    logic adj_reg, chg_reg, net_chg_reg;         // one-cycle-late write effects
    cycle_state_t state_reg;
    logic [TW-1:0] phase_reg;                    // ms left in current phase
    logic [MW-1:0] missed_reg;
    logic seen_reg, synced_reg, coord_reg, push_reg;
    logic [TW-1:0] hold_left_reg;                // button wake hold-off
    logic btn_meta_reg, btn_sync_reg, btn_prev_reg;
    logic [TW-1:0] press_ms_reg, win_ms_reg;
    logic [1:0] press_cnt_reg;
    logic [TW-1:0] led_cnt_reg;
    logic led_reg, tx_valid_reg, req_reg, awake_reg;
    sync_msg_t tx_msg_reg;
    logic [TW-1:0] guard_reg, window_reg;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire tick = (tick_cnt_reg == 32'(MS_TICK_CYC - 1));
    wire apb_first = i_psel & i_penable & ~pready_reg;
    wire apb_done = i_psel & i_penable & pready_reg;
    wire hit_ctrl = (i_paddr == ADDR_CTRL);
    wire hit_sleep = (i_paddr == ADDR_SLEEP);
    wire hit_wake = (i_paddr == ADDR_WAKE);
    wire hit_net = (i_paddr == ADDR_NET);
    wire hit_asl = (i_paddr == ADDR_ACT_SLEEP);
    wire hit_awk = (i_paddr == ADDR_ACT_WAKE);
    wire hit_st = (i_paddr == ADDR_STATUS);
    wire hit_sync_propagation_time = (i_paddr == ADDR_SYNC_PROPAGATION_TIME);
    wire mapped = hit_ctrl | hit_sleep | hit_wake | hit_net | hit_asl | hit_awk | hit_st | hit_sync_propagation_time;
    // writes land only on the edge that sees pready high
    wire wr = apb_done & i_pwrite;
    wire wr_ctrl = wr & hit_ctrl;
    wire wr_sleep = wr & hit_sleep;
    wire wr_wake = wr & hit_wake;
    wire wr_net = wr & hit_net;

    // ----------------------------------------
    // mode and active values
    // ----------------------------------------
    wire [3:0] mode = ctrl_reg[CTRL_MODE_MSB:CTRL_MODE_LSB];
    wire is_support = (mode == MODE_SUPPORT);
    wire is_cyclic = (mode == MODE_CYCLIC);
    wire capable = is_support | is_cyclic;
    wire noncoord = ctrl_reg[CTRL_NONCOORD];
    wire early_en = ~ctrl_reg[CTRL_EARLY_DIS];
    // network values once synced or coordinating, else local
    wire use_net = synced_reg | coord_reg;
    wire [TW-1:0] act_sleep = use_net ? net_msg_reg.sleep_ms : sleep_reg;
    wire [TW-1:0] act_wake = use_net ? net_msg_reg.wake_ms : wake_reg;
    wire [23:0] sync_propagation_time = calc_sync_propagation_time(net_reg);
    // minimum wake: propagation plus a drift share of the sleep period
    wire [TW-1:0] min_wake = clip(sync_propagation_time + 24'(sleep_reg >> DRIFT_SHIFT));

    // ----------------------------------------
    // commissioning button
    // ----------------------------------------
    wire btn = btn_sync_reg;
    wire btn_fall = ~btn & btn_prev_reg;
    wire hold_hit = btn & tick & (press_ms_reg == BTN_HOLD_MS - 16'd1);
    wire short_rel = btn_fall & (press_ms_reg < BTN_HOLD_MS);
    wire win_end = (press_cnt_reg != 2'd0) & ~btn & tick & (win_ms_reg == PRESS_WIN_MS - 16'd1);
    wire single_press = win_end & (press_cnt_reg == 2'd1);
    wire double_press = win_end & (press_cnt_reg == 2'd2);

    // ----------------------------------------
    // coordinator decisions
    // ----------------------------------------
    wire local_differs = (sleep_reg != net_msg_reg.sleep_ms) | (wake_reg != net_msg_reg.wake_ms);
    // the non-coordinator option or a mode other than support or cyclic blocks taking the role
    wire may_coord = capable & ~noncoord;
    wire become = may_coord & ((chg_reg & local_differs) | net_chg_reg);
    wire nominate = may_coord & double_press;
    wire pref = may_coord & ctrl_reg[CTRL_PREF];

    // ----------------------------------------
    // cycle schedule
    // ----------------------------------------
    wire phase_end = tick & (phase_reg == 16'd0);
    wire wake_start = capable & phase_end & (state_reg == CYC_ASLEEP);
    wire go_sleep = capable & phase_end & (state_reg == CYC_AWAKE);
    // the coordinator never accepts syncs; election is not modelled
    wire sync_ok = capable & i_sync_rx_valid & ~coord_reg;
    wire btn_wake = capable & ((single_press & synced_reg & (state_reg == CYC_ASLEEP)) | hold_hit);
    wire coord_send = wake_start & coord_reg;
    wire [TW-1:0] wake_load = (coord_reg & push_reg) ? wake_reg : act_wake;
    wire [23:0] early_off = early_en ? 24'(missed_reg) * 24'(EARLY_STEP_MS) : 24'd0;
    wire [TW-1:0] eff_sleep = sub_min1(act_sleep, early_off);
    wire [23:0] guard_w = 24'(GUARD_BASE_MS) + 24'(missed_reg) * 24'(GUARD_STEP_MS)
                          + 24'(act_sleep >> DRIFT_SHIFT);
    wire [TW-1:0] guard = clip(guard_w);
    wire [16:0] two_guard = {guard, 1'b0};
    wire [TW-1:0] window = (17'(act_wake) > two_guard) ? act_wake - two_guard[TW-1:0] : 16'd0;
    // support and normal nodes never drop their receiver
    wire awake = ~is_cyclic | (state_reg == CYC_AWAKE) | (hold_left_reg != 16'd0);
    wire req_answer = i_sync_req_rx & awake_reg & use_net & capable;

    // ----------------------------------------
    // next values
    // ----------------------------------------
    wire [CW-1:0] ctrl_next = wr_ctrl ? i_pwdata[CW-1:0] : ctrl_reg;
    wire [TW-1:0] sleep_next = wr_sleep ? i_pwdata[TW-1:0] : sleep_reg;
    wire [TW-1:0] wake_next = wr_wake ? i_pwdata[TW-1:0] :
                              (adj_reg & (wake_reg < min_wake)) ? min_wake : wake_reg;
    wire [31:0] net_next = wr_net ? i_pwdata : net_reg;
    // received values kept apart from local settings
    wire sync_msg_t net_msg_next = sync_ok ? i_sync_rx_msg :
                                   (coord_send & push_reg) ? {sleep_reg, wake_reg} : net_msg_reg;
    wire cycle_state_t state_next = ~capable ? CYC_ASLEEP :
                                    (sync_ok | wake_start | btn_wake) ? CYC_AWAKE :
                                    go_sleep ? CYC_ASLEEP : state_reg;
    wire [TW-1:0] phase_next = ~capable ? 16'd0 :
                               sync_ok ? i_sync_rx_msg.wake_ms :
                               (wake_start | btn_wake) ? wake_load :
                               go_sleep ? eff_sleep :
                               (tick & (phase_reg != 16'd0)) ? phase_reg - 16'd1 : phase_reg;
    wire miss_inc = wake_start & synced_reg & ~coord_reg & ~seen_reg & (missed_reg != {MW{1'b1}});
    wire [MW-1:0] missed_next = sync_ok ? '0 : miss_inc ? missed_reg + 1'b1 : missed_reg;
    wire seen_next = sync_ok | (seen_reg & ~wake_start);
    wire synced_next = capable & (sync_ok | synced_reg);
    wire coord_next = capable & (become | nominate | pref | coord_reg);
    wire push_next = capable & (become | (push_reg & ~coord_send));
    wire [TW-1:0] hold_next = hold_hit ? WAKE_HOLD_MS :
                              (tick & (hold_left_reg != 16'd0)) ? hold_left_reg - 16'd1 : hold_left_reg;
    wire [TW-1:0] press_next = ~btn ? 16'd0 :
                               (tick & (press_ms_reg != BTN_HOLD_MS)) ? press_ms_reg + 16'd1 : press_ms_reg;
    wire [1:0] pcnt_next = win_end ? 2'd0 :
                           (short_rel & (press_cnt_reg != 2'd2)) ? press_cnt_reg + 2'd1 : press_cnt_reg;
    wire [TW-1:0] win_next = (short_rel | win_end) ? 16'd0 :
                             ((press_cnt_reg != 2'd0) & tick) ? win_ms_reg + 16'd1 : win_ms_reg;
    wire led_en = coord_reg | (synced_reg & awake_reg);
    wire [TW-1:0] led_period = coord_reg ? LED_SLOW_MS : LED_FAST_MS;
    wire led_wrap = tick & (led_cnt_reg >= led_period - 16'd1);
    wire [TW-1:0] led_cnt_next = ~led_en ? 16'd0 : led_wrap ? 16'd0 : tick ? led_cnt_reg + 16'd1 : led_cnt_reg;
    wire led_next = led_en & (led_wrap ? ~led_reg : led_reg);
    wire sync_msg_t tx_msg_next = (coord_send & push_reg) ? {sleep_reg, wake_reg} : net_msg_reg;
    wire req_next = wake_start & ~synced_reg & ~coord_reg & is_cyclic;

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    wire [31:0] status_w = {16'd0, missed_reg, 4'd0, push_reg, synced_reg, awake_reg, coord_reg};
    wire [31:0] rd_data = hit_ctrl ? 32'(ctrl_reg) :
                          hit_sleep ? 32'(sleep_reg) :
                          hit_wake ? 32'(wake_reg) :
                          hit_net ? net_reg :
                          hit_asl ? 32'(act_sleep) :
                          hit_awk ? 32'(act_wake) :
                          hit_st ? status_w :
                          hit_sync_propagation_time ? 32'(sync_propagation_time) : 32'd0;

    // ----------------------------------------
    // bus slave registers
    // ----------------------------------------
    // one wait state; unmapped reads zero with pslverr
    always_ff @(posedge i_ref_clk) begin
        pready_reg <= ~i_srst & apb_first;
        pslverr_reg <= ~i_srst & apb_first & ~mapped;
        prdata_reg <= i_srst ? 32'd0 : apb_first ? rd_data : prdata_reg;
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ctrl_reg <= CTRL_RST;                // normal, non-sleeping
            sleep_reg <= SLEEP_RST;
            wake_reg <= WAKE_RST;
            net_reg <= NET_RST;
            adj_reg <= 1'b0;
            chg_reg <= 1'b0;
            net_chg_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            sleep_reg <= sleep_next;
            wake_reg <= wake_next;
            net_reg <= net_next;
            adj_reg <= wr_sleep | wr_net;
            chg_reg <= wr_sleep | wr_wake;
            net_chg_reg <= wr_net;
        end
    end

    // ----------------------------------------
    // schedule and sync state
    // ----------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            tick_cnt_reg <= 32'd0;
            net_msg_reg <= {SLEEP_RST, WAKE_RST};
            state_reg <= CYC_ASLEEP;
            phase_reg <= 16'd0;
            missed_reg <= '0;
            seen_reg <= 1'b0;
            synced_reg <= 1'b0;
            coord_reg <= 1'b0;
            push_reg <= 1'b0;
            hold_left_reg <= 16'd0;
        end else begin
            tick_cnt_reg <= tick ? 32'd0 : tick_cnt_reg + 32'd1;
            net_msg_reg <= net_msg_next;
            state_reg <= state_next;
            phase_reg <= phase_next;
            missed_reg <= missed_next;
            seen_reg <= seen_next;
            synced_reg <= synced_next;
            coord_reg <= coord_next;
            push_reg <= push_next;
            hold_left_reg <= hold_next;
        end
    end

    // ----------------------------------------
    // button synchroniser and press timing
    // ----------------------------------------
    // pin is asynchronous; meta stage feeds only the sync stage
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            btn_meta_reg <= 1'b0;
            btn_sync_reg <= 1'b0;
            btn_prev_reg <= 1'b0;
            press_ms_reg <= 16'd0;
            press_cnt_reg <= 2'd0;
            win_ms_reg <= 16'd0;
        end else begin
            btn_meta_reg <= i_commission_btn;
            btn_sync_reg <= btn_meta_reg;
            btn_prev_reg <= btn_sync_reg;
            press_ms_reg <= press_next;
            press_cnt_reg <= pcnt_next;
            win_ms_reg <= win_next;
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            led_cnt_reg <= 16'd0;
            led_reg <= 1'b0;
            tx_valid_reg <= 1'b0;
            tx_msg_reg <= '0;
            req_reg <= 1'b0;
            awake_reg <= 1'b1;
            guard_reg <= 16'd0;
            window_reg <= 16'd0;
        end else begin
            led_cnt_reg <= led_cnt_next;
            led_reg <= led_next;
            tx_valid_reg <= coord_send | req_answer;
            tx_msg_reg <= tx_msg_next;
            req_reg <= req_next;
            awake_reg <= awake;
            guard_reg <= guard;
            window_reg <= window;
        end
    end

    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    assign o_sync_tx_valid = tx_valid_reg;
    assign o_sync_tx_msg = tx_msg_reg;
    assign o_sync_req_tx = req_reg;
    assign o_awake = awake_reg;
    assign o_assoc_led = led_reg;
    assign o_coordinator = coord_reg;
    assign o_guard_ms = guard_reg;
    assign o_tx_window_ms = window_reg;

endmodule : sleep_sync_coordinator

// ==== include/sleep_sync_pkg.sv ====
package sleep_sync_pkg;

    // ----------------------------------------
    // widths and carriers
    // ----------------------------------------
    localparam int TW = 16;                      // time fields, in ms
    localparam int AW = 8;                       // apb address width
    localparam int MW = 8;                       // missed-sync counter width
    localparam int CW = 7;                       // control register width

    // sync message contents, one record per message
    typedef struct packed {
        logic [TW-1:0] sleep_ms;
        logic [TW-1:0] wake_ms;
    } sync_msg_t;

    // cycle phase of a sleep-compatible node
    typedef enum logic [0:0] {
        CYC_AWAKE = 1'b0,
        CYC_ASLEEP = 1'b1
    } cycle_state_t;

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [AW-1:0] ADDR_SLEEP = 8'h04;
    localparam logic [AW-1:0] ADDR_WAKE = 8'h08;
    localparam logic [AW-1:0] ADDR_NET = 8'h0C;
    localparam logic [AW-1:0] ADDR_ACT_SLEEP = 8'h10;
    localparam logic [AW-1:0] ADDR_ACT_WAKE = 8'h14;
    localparam logic [AW-1:0] ADDR_STATUS = 8'h18;
    localparam logic [AW-1:0] ADDR_SYNC_PROPAGATION_TIME = 8'h1C;

    // control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_MSB = 3;
    localparam int CTRL_EARLY_DIS = 4;
    localparam int CTRL_NONCOORD = 5;
    localparam int CTRL_PREF = 6;
    localparam logic [3:0] MODE_SUPPORT = 4'h7;
    localparam logic [3:0] MODE_CYCLIC = 4'h8;

    // network parameter fields
    localparam int NET_HOP_LSB = 0;
    localparam int NET_SLOT_LSB = 8;

    // status fields
    localparam int ST_COORD = 0;
    localparam int ST_AWAKE = 1;
    localparam int ST_SYNCED = 2;
    localparam int ST_PUSH = 3;
    localparam int ST_MISS_LSB = 8;

    // reset values
    localparam logic [CW-1:0] CTRL_RST = 7'h00;
    localparam logic [TW-1:0] SLEEP_RST = 16'h00C8;
    localparam logic [TW-1:0] WAKE_RST = 16'h07D0;
    localparam logic [31:0] NET_RST = 32'h0000_0307;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_HZ = 25000000;
    localparam int MS_PER_S = 1000;
    localparam int MS_TICK_DEFAULT = CLK_HZ / MS_PER_S;
    localparam int SYNC_PROPAGATION_TIME_UNIT_MS = 16;
    localparam logic [TW-1:0] BTN_HOLD_MS = 16'd2000;
    localparam logic [TW-1:0] WAKE_HOLD_MS = 16'd30000;
    localparam logic [TW-1:0] PRESS_WIN_MS = 16'd500;
    localparam logic [TW-1:0] LED_SLOW_MS = 16'd1000;
    localparam logic [TW-1:0] LED_FAST_MS = 16'd250;
    localparam int GUARD_BASE_MS = 4;
    localparam int GUARD_STEP_MS = 8;
    localparam int EARLY_STEP_MS = 8;
    localparam int DRIFT_SHIFT = 6;

endpackage : sleep_sync_pkg

// ==== verification/sleep_sync_checker.sv ====
module sleep_sync_checker import sleep_sync_pkg::*; #(
    parameter int unsigned MS_TICK_CYC = MS_TICK_DEFAULT
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic i_sync_rx_valid,
    input wire sync_msg_t i_sync_rx_msg,
    input wire logic i_sync_req_rx,
    input wire logic o_sync_tx_valid,
    input wire logic o_sync_req_tx,
    input wire logic o_awake,
    input wire logic o_assoc_led,
    input wire logic o_coordinator,
    input wire logic [TW-1:0] o_guard_ms
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    // ----------------------------------------
    // mode shadow from completed control writes
    // ----------------------------------------
    logic [3:0] mode_reg; // last written mode
    logic [2:0] age_reg; // cycles since control write, stops at 4
    logic [1:0] run_reg; // cycles since reset release
    logic [TW-1:0] rx_sleep_reg; // sleep field of the last received sync
    wire ctrl_wr = i_psel && i_penable && o_pready && i_pwrite && i_paddr == ADDR_CTRL;
    // side effects lag a write by up to two cycles, so wait four
    wire settled = age_reg == 3'h4;
    wire capable = settled && (mode_reg == MODE_SUPPORT || mode_reg == MODE_CYCLIC);
    // shadow registers
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            mode_reg <= 4'h0;
            age_reg <= 3'h4;
            run_reg <= 2'h0;
        end else begin
            if (ctrl_wr) mode_reg <= i_pwdata[3:0];
            age_reg <= ctrl_wr ? 3'h0 : age_reg + {2'h0, !settled};
            run_reg <= run_reg + {1'b0, run_reg != 2'h3};
        end
        if (i_sync_rx_valid) rx_sleep_reg <= i_sync_rx_msg.sleep_ms;
    end
    AST_NORMAL_AWAKE: assert property (settled && !capable |-> o_awake && !o_coordinator)
        else $error("normal mode node asleep or coordinating");
    AST_SUPPORT_AWAKE: assert property (settled && mode_reg == MODE_SUPPORT |-> o_awake)
        else $error("support node asleep");
    AST_REQ_ANSWER: assert property (i_sync_req_rx && o_awake && o_coordinator |=> o_sync_tx_valid)
        else $error("sync request not answered");
    AST_TX_CAUSE: assert property (o_sync_tx_valid |-> $past(i_sync_req_rx) || $past(o_coordinator))
        else $error("sync sent without cause");
    AST_REQ_CYCLIC: assert property (o_sync_req_tx |-> mode_reg == MODE_CYCLIC && !o_coordinator)
        else $error("sync request outside cyclic mode");
    AST_GUARD_MIN: assert property (run_reg == 2'h3 |-> int'(o_guard_ms) >= GUARD_BASE_MS)
        else $error("guard below base");
    AST_SYNC_CLEARS: assert property (i_sync_rx_valid && capable && !o_coordinator |=> ##[0:2] int'(o_guard_ms) == GUARD_BASE_MS + int'(rx_sleep_reg >> DRIFT_SHIFT))
        else $error("guard not at minimum after sync");
    AST_LED_DARK: assert property ((!o_awake && !o_coordinator)[*3] |-> !o_assoc_led)
        else $error("indicator lit while asleep");
endmodule : sleep_sync_checker

bind sleep_sync_coordinator sleep_sync_checker #(.MS_TICK_CYC(MS_TICK_CYC)) sleep_sync_checker_i (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .i_sync_rx_valid(i_sync_rx_valid), .i_sync_rx_msg(i_sync_rx_msg),
    .i_sync_req_rx(i_sync_req_rx), .o_sync_tx_valid(o_sync_tx_valid),
    .o_sync_req_tx(o_sync_req_tx), .o_awake(o_awake), .o_assoc_led(o_assoc_led),
    .o_coordinator(o_coordinator), .o_guard_ms(o_guard_ms));

// ==== verification/sync_peer.sv ====
module sync_peer import sleep_sync_pkg::*; (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_req, // node broadcasts a sync request
    input wire logic i_ask, // bench: send one request to the node
    input wire logic [3:0] i_lag, // answer delay, 1 is prompt
    input wire sync_msg_t i_net, // schedule this peer follows
    output logic o_valid,
    output sync_msg_t o_msg,
    output logic o_req
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_reg; // countdown to the answer
    sync_msg_t last_reg; // last message sent
    wire fire = wait_reg == 4'h1;
    // idle lines show the inverse so a stale value is never mistaken for data
    assign o_msg = o_valid ? last_reg : ~last_reg;
    // awake peer answers every request with a sync
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            wait_reg <= 4'h0;
            o_valid <= 1'b0;
            o_req <= 1'b0;
            last_reg <= '0;
        end else begin
            o_valid <= fire;
            o_req <= i_ask;
            if (fire) last_reg <= i_net;
            wait_reg <= i_req ? i_lag : wait_reg - {3'h0, wait_reg != 4'h0};
        end
    end
endmodule : sync_peer

// ==== verification/tb.sv ====
module tb import sleep_sync_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TK = 2; // cycles per ms, shortened
    logic i_ref_clk = 1'b0, i_srst = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
    logic i_pwrite = 1'b0, i_commission_btn = 1'b0, ask = 1'b0, led0, e;
    logic [AW-1:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0000_0000, o_prdata, q, rs = 32'd80821;
    logic o_pready, o_pslverr, i_sync_rx_valid, i_sync_req_rx, o_sync_tx_valid;
    logic o_sync_req_tx, o_awake, o_assoc_led, o_coordinator;
    logic [3:0] lag = 4'h1;
    logic [TW-1:0] o_guard_ms, o_tx_window_ms;
    sync_msg_t i_sync_rx_msg, o_sync_tx_msg, net = 32'h0000_0000;
    int err_count = 0, compares = 0, n, ns, nw, g;
    // bench model of the local settings
    int sl = SLEEP_RST, wk = 10, hop, slot;
    always #20 i_ref_clk = ~i_ref_clk;
    sleep_sync_coordinator #(.MS_TICK_CYC(TK)) sleep_sync_coordinator_i (.i_ref_clk, .i_srst,
        .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
        .i_commission_btn, .i_sync_rx_valid, .i_sync_rx_msg, .i_sync_req_rx, .o_sync_tx_valid,
        .o_sync_tx_msg, .o_sync_req_tx, .o_awake, .o_assoc_led, .o_coordinator, .o_guard_ms,
        .o_tx_window_ms);
    sync_peer sync_peer_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_req(o_sync_req_tx),
        .i_ask(ask), .i_lag(lag), .i_net(net), .o_valid(i_sync_rx_valid),
        .o_msg(i_sync_rx_msg), .o_req(i_sync_req_rx));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("mismatches %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    // apb transfer, held until pready is sampled
    task automatic apb(input logic w, input logic [AW-1:0] a, input int d);
        n = 0;
        @(posedge i_ref_clk);
        {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        do @(posedge i_ref_clk); while (o_pready !== 1'b1 && ++n < 20);
        {q, e} = {o_prdata, o_pslverr};
        {i_psel, i_penable} <= 2'b00;
        if (n >= 20) begin err_count++; end_sim(); end
    endtask : apb
    task automatic rd(input logic [AW-1:0] a, input int exp);
        apb(1'b0, a, 0);
        chk(q, exp);
    endtask : rd
    // bounded wait: 0 request, 1 sync sent, 2 coordinator, 3 indicator edge
    task automatic wt(input int s, input int lim);
        logic c;
        n = 0;
        do begin
            @(posedge i_ref_clk);
            n++;
            c = s == 0 ? o_sync_req_tx : s == 1 ? o_sync_tx_valid :
                s == 2 ? o_coordinator : o_assoc_led ^ led0;
        end while (c !== 1'b1 && n < lim);
        if (n >= lim) begin err_count++; end_sim(); end
    endtask : wt
    task automatic clamp; // wake time rises to its minimum
        wk = wk < hop * slot * SYNC_PROPAGATION_TIME_UNIT_MS + (sl >> 6) ? hop * slot * SYNC_PROPAGATION_TIME_UNIT_MS + (sl >> 6) : wk;
    endtask : clamp
    task automatic press;
        i_commission_btn <= 1'b1;
        repeat (40) @(posedge i_ref_clk);
        i_commission_btn <= 1'b0;
        repeat (40) @(posedge i_ref_clk);
    endtask : press
    initial begin
        repeat (8) @(posedge i_ref_clk);
        i_srst <= 1'b0;
        @(posedge i_ref_clk);
        chk({o_awake, o_coordinator}, 32'h0000_0002);
        rd(ADDR_SLEEP, SLEEP_RST);
        rd(ADDR_SYNC_PROPAGATION_TIME, NET_RST[7:0] * NET_RST[15:8] * SYNC_PROPAGATION_TIME_UNIT_MS);
        apb(1'b0, 8'h20, 0);
        chk({q[30:0], e}, 32'h0000_0001);
        apb(1'b1, ADDR_WAKE, wk);
        rs = xs(rs);
        {hop, slot} = {29'h0, {1'b0, rs[1:0]} + 3'h1, 29'h0, {1'b0, rs[3:2]} + 3'h1};
        apb(1'b1, ADDR_NET, {slot[7:0], hop[7:0]});
        clamp();
        rd(ADDR_SYNC_PROPAGATION_TIME, hop * slot * SYNC_PROPAGATION_TIME_UNIT_MS);
        rd(ADDR_WAKE, wk);
        apb(1'b1, ADDR_CTRL, MODE_SUPPORT);
        press();
        press();
        wt(2, 3000);
        chk(o_awake, 1'b1);
        ask <= 1'b1;
        @(posedge i_ref_clk);
        ask <= 1'b0;
        wt(1, 10);
        chk(n, 2);
        apb(1'b1, ADDR_CTRL, 0);
        rs = xs(rs);
        {ns, nw} = {100 + rs[7:0], 200 + rs[15:8]};
        net <= {ns[15:0], nw[15:0]};
        lag <= {1'b0, rs[18:16]} + 4'h1;
        // the role drops one edge after the mode write lands
        repeat (2) @(posedge i_ref_clk);
        chk(o_coordinator, 1'b0);
        apb(1'b1, ADDR_CTRL, MODE_CYCLIC);
        wt(0, 20000);
        repeat (12) @(posedge i_ref_clk);
        g = GUARD_BASE_MS + (ns >> 6);
        chk(o_guard_ms, g);
        chk(o_tx_window_ms, nw - 2 * g);
        rd(ADDR_ACT_SLEEP, ns);
        rd(ADDR_ACT_WAKE, nw);
        rd(ADDR_SLEEP, sl);
        sl = ns + 1;
        apb(1'b1, ADDR_SLEEP, sl);
        clamp();
        wt(2, 5);
        chk(o_coordinator, 1'b1);
        wt(1, 20000);
        chk(o_sync_tx_msg, {sl[15:0], wk[15:0]});
        led0 = o_assoc_led;
        wt(3, 5000);
        led0 = o_assoc_led;
        wt(3, 5000);
        chk(n, LED_SLOW_MS * TK);
        end_sim();
    end
endmodule : tb
